/* File: rsa_pkg.sv */
/*
 * Constants shared by the radio status and address register block:
 * serial command fields, register offsets, status bit positions, reset
 * values and address width codes.
 * Assumes every design file of the block imports it whole.
 */
package rsa_pkg;

    // ------------------------------------------------------------
    // serial command word
    // ------------------------------------------------------------
    localparam int CMD_OP_HI = 7;
    localparam int CMD_OP_LO = 5;
    localparam int CMD_ADDR_HI = 4;
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] REG_RADIO_CHANNEL = 5'h05;
    localparam logic [4:0] REG_RADIO_STATUS = 5'h07;
    localparam logic [4:0] REG_TRANSMIT_OBSERVE = 5'h08;
    localparam logic [4:0] REG_RECEIVED_POWER_DETECT = 5'h09;
    localparam logic [4:0] REG_PIPE0_RECEIVE_ADDRESS = 5'h0A;
    localparam logic [4:0] REG_PIPE1_RECEIVE_ADDRESS = 5'h0B;
    localparam logic [4:0] REG_PIPE2_ADDRESS_LOW_BYTE = 5'h0C;
    localparam logic [4:0] REG_PIPE3_ADDRESS_LOW_BYTE = 5'h0D;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STAT_RX_BIT = 6;
    localparam int STAT_TX_BIT = 5;
    localparam int STAT_MAX_BIT = 4;
    localparam int STAT_PIPE_HI = 3;
    localparam int STAT_PIPE_LO = 1;
    localparam int STAT_FULL_BIT = 0;
    localparam int OBS_LOST_HI = 7;
    localparam int OBS_LOST_LO = 4;
    localparam int OBS_RETRY_HI = 3;
    localparam int OBS_RETRY_LO = 0;
    localparam int POWER_BIT = 0;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [2:0] PIPE_FIFO_EMPTY = 3'h7;
    localparam logic [39:0] PIPE0_RESET = 40'hE7E7E7E7E7;
    localparam logic [39:0] PIPE1_RESET = 40'hC2C2C2C2C2;
    localparam logic [7:0] PIPE2_RESET = 8'hC3;
    localparam logic [7:0] PIPE3_RESET = 8'hC4;
    localparam logic [3:0] COUNT_MAX = 4'hF;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // address width setting
    // ------------------------------------------------------------
    localparam logic [1:0] AW_ILLEGAL = 2'h0;
    localparam logic [1:0] AW_3_BYTES = 2'h1;
    localparam logic [1:0] AW_4_BYTES = 2'h2;
    localparam logic [1:0] AW_5_BYTES = 2'h3;
    localparam logic [2:0] BYTES_3 = 3'h3;
    localparam logic [2:0] BYTES_4 = 3'h4;
    localparam logic [2:0] BYTES_5 = 3'h5;
    localparam logic [2:0] BYTES_NONE = 3'h0;

    // transfer state, gray along idle -> command -> data -> ignore
    typedef enum logic [1:0] {
        RSA_IDLE = 2'b00,
        RSA_CMD = 2'b01,
        RSA_DATA = 2'b11,
        RSA_IGNORE = 2'b10
    } rsa_state_type;

endpackage

/* File: rsa_pin_sync.sv */
/*
 * Three-stage synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to sys_clk; the output changes
 * only once the second and third stages agree.
 */
`timescale 1ns/1ns
`default_nettype none
module rsa_pin_sync
    import rsa_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    // ------------------------------------------------------------
    // per-bit chain
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q, s2_q, s3_q, out_q;
            // first stage feeds only the second
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    s1_q <= RESET_VALUE[i];
                    s2_q <= RESET_VALUE[i];
                    s3_q <= RESET_VALUE[i];
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    out_q <= RESET_VALUE[i];
                end else if (s2_q == s3_q) begin
                    out_q <= s3_q;
                end
            end
            assign pin_out[i] = out_q;
        end
    endgenerate

endmodule
`default_nettype wire

/* File: rsa_spi_shift.sv */
/*
 * Serial link byte engine, mode 0, msb first, on synchronised pins.
 * Assumes sck at most sys_clk/8, so each next byte settles in time.
 */
`timescale 1ns/1ns
`default_nettype none
module rsa_spi_shift
    import rsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sck_s,
    input wire logic csn_s,
    input wire logic mosi_s,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic frame_start,
    output logic frame_end,
    output logic miso_bit
);

    logic sck_d_q, csn_d_q, reload_q;
    logic [2:0] bit_q;
    logic [7:0] rx_sr_q, tx_sr_q, rx_byte_q;
    logic rx_valid_q, sck_rise, sck_fall;

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    assign sck_rise = sck_s & ~sck_d_q & ~csn_s;
    assign sck_fall = ~sck_s & sck_d_q & ~csn_s;
    assign frame_start = ~csn_s & csn_d_q;
    assign frame_end = csn_s & ~csn_d_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_d_q <= 1'b0;
            csn_d_q <= 1'b1;
        end else begin
            sck_d_q <= sck_s;
            csn_d_q <= csn_s;
        end
    end

    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst || frame_start) begin
            bit_q <= 3'h0;
            rx_sr_q <= BYTE_ZERO;
        end else if (sck_rise) begin
            bit_q <= bit_q + 3'h1;
            rx_sr_q <= {rx_sr_q[6:0], mosi_s};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_valid_q <= 1'b0;
            rx_byte_q <= BYTE_ZERO;
        end else begin
            rx_valid_q <= sck_rise && (bit_q == BIT_LAST);
            if (sck_rise && (bit_q == BIT_LAST)) begin
                rx_byte_q <= {rx_sr_q[6:0], mosi_s};
            end
        end
    end

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst || frame_start) begin
            reload_q <= 1'b0;
        end else if (sck_rise && (bit_q == BIT_LAST)) begin
            reload_q <= 1'b1;
        end else if (sck_fall) begin
            reload_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_sr_q <= BYTE_ZERO;
        end else if (frame_start) begin
            tx_sr_q <= tx_byte;
        end else if (sck_fall) begin
            tx_sr_q <= reload_q ? tx_byte : {tx_sr_q[6:0], 1'b0};
        end
    end

    assign rx_byte = rx_byte_q;
    assign rx_valid = rx_valid_q;
    assign miso_bit = tx_sr_q[7];

endmodule
`default_nettype wire

/* File: rsa_radio_regs.sv */
/*
 * Radio status, transmit-observe, power-detect and pipe 0..3 addresses.
 * Assumes engine events on sys_clk; link pins are asynchronous.
 */
// Behaviour
// - status shifts out during every command byte
// - bit 6 set on new payload, one clears
// - bit 5 set on send when auto-ack is off, on ack when auto-ack is on, one clears
// - bit 4 set at retry limit, blocks traffic
// - bits 3:1 give head pipe, 111 empty
// - bit 0 shows transmit fifo full
// - lost packet count saturates at fifteen
// - channel register write clears lost count
// - retry count cleared at new packet start
// - power detect in bit 0, rest zero
// - pipe 0 address, low byte first, width-long
// - pipe 1 address, low byte first, width-long
// - pipes 2,3 share pipe 1 upper bytes
// - pipe 2 resets C3, pipe 3 C4
// - width code 01/10/11 gives 3/4/5 bytes
`timescale 1ns/1ns
`default_nettype none
module rsa_radio_regs
    import rsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_sck,
    input wire logic spi_csn_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic payload_received,
    input wire logic packet_sent,
    input wire logic ack_received,
    input wire logic auto_ack_enable,
    input wire logic retry_limit_reached,
    input wire logic packet_lost,
    input wire logic packet_retransmitted,
    input wire logic new_packet_start,
    input wire logic [2:0] head_pipe_number,
    input wire logic transmit_fifo_full,
    input wire logic power_detect_in,
    input wire logic [1:0] address_width_setting,
    output logic receive_ready_flag,
    output logic transmit_done_flag,
    output logic retry_limit_flag,
    output logic communication_blocked,
    output logic radio_channel_write,
    output logic [39:0] pipe0_receive_address,
    output logic [39:0] pipe1_receive_address,
    output logic [39:0] pipe2_receive_address,
    output logic [39:0] pipe3_receive_address
);

    // ------------------------------------------------------------
    // link pins
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic sck_s, csn_s, mosi_s;
    logic [7:0] rx_byte, tx_byte_d;
    logic rx_valid, frame_start, frame_end, miso_bit;

    rsa_pin_sync #(.WIDTH(3), .RESET_VALUE(3'b010)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_in({spi_sck, spi_csn_n, spi_mosi}),
        .pin_out(pins_s)
    );

    assign sck_s = pins_s[2];
    assign csn_s = pins_s[1];
    assign mosi_s = pins_s[0];
    rsa_spi_shift u_shift (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sck_s(sck_s),
        .csn_s(csn_s),
        .mosi_s(mosi_s),
        .tx_byte(tx_byte_d),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .frame_start(frame_start),
        .frame_end(frame_end),
        .miso_bit(miso_bit)
    );

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    rsa_state_type state_q;
    logic is_write_q;
    logic [4:0] reg_addr_q;
    logic [2:0] byte_idx_q, cmd_op;
    logic cmd_byte, data_byte, wr_byte, cmd_known;
    assign cmd_byte = rx_valid && (state_q == RSA_CMD);
    assign data_byte = rx_valid && (state_q == RSA_DATA);
    assign wr_byte = data_byte && is_write_q;
    assign cmd_op = rx_byte[CMD_OP_HI:CMD_OP_LO];
    assign cmd_known = cmd_op == OP_READ || cmd_op == OP_WRITE;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= RSA_IDLE;
        end else if (frame_end) begin
            state_q <= RSA_IDLE;
        end else begin
            case (state_q)
                RSA_IDLE: begin
                    if (frame_start) begin
                        state_q <= RSA_CMD;
                    end
                end
                RSA_CMD: begin
                    if (rx_valid) begin
                        state_q <= cmd_known ? RSA_DATA : RSA_IGNORE;
                    end
                end
                RSA_DATA, RSA_IGNORE: state_q <= state_q;
                default: state_q <= RSA_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            is_write_q <= 1'b0;
            reg_addr_q <= 5'h00;
        end else if (cmd_byte) begin
            is_write_q <= cmd_op == OP_WRITE;
            reg_addr_q <= rx_byte[CMD_ADDR_HI:0];
        end
    end
    // saturates so long transfers do not wrap onto low bytes
    always_ff @(posedge sys_clk) begin
        if (sys_rst || cmd_byte) begin
            byte_idx_q <= 3'h0;
        end else if (data_byte && byte_idx_q != BIT_LAST) begin
            byte_idx_q <= byte_idx_q + 3'h1;
        end
    end
    // ------------------------------------------------------------
    // address width
    // ------------------------------------------------------------
    logic [2:0] addr_bytes;

    // illegal code stores no pipe 0 or pipe 1 address bytes
    always_comb begin
        case (address_width_setting)
            AW_3_BYTES: addr_bytes = BYTES_3;
            AW_4_BYTES: addr_bytes = BYTES_4;
            AW_5_BYTES: addr_bytes = BYTES_5;
            default: addr_bytes = BYTES_NONE;
        endcase
    end
    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic rx_flag_q, tx_flag_q, max_flag_q;
    logic status_wr, done_event;
    logic [2:0] pipe_q;
    logic full_q;

    assign status_wr = wr_byte && reg_addr_q == REG_RADIO_STATUS &&
                       byte_idx_q == 3'h0;
    assign done_event = auto_ack_enable ? ack_received : packet_sent;
    // a set in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_flag_q <= 1'b0;
        end else if (payload_received) begin
            rx_flag_q <= 1'b1;
        end else if (status_wr && rx_byte[STAT_RX_BIT]) begin
            rx_flag_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_flag_q <= 1'b0;
        end else if (done_event) begin
            tx_flag_q <= 1'b1;
        end else if (status_wr && rx_byte[STAT_TX_BIT]) begin
            tx_flag_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            max_flag_q <= 1'b0;
        end else if (retry_limit_reached) begin
            max_flag_q <= 1'b1;
        end else if (status_wr && rx_byte[STAT_MAX_BIT]) begin
            max_flag_q <= 1'b0;
        end
    end
    // read-only fields follow the engine, never the link
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pipe_q <= PIPE_FIFO_EMPTY;
            full_q <= 1'b0;
        end else begin
            pipe_q <= head_pipe_number;
            full_q <= transmit_fifo_full;
        end
    end

    // ------------------------------------------------------------
    // transmit observe and power detect
    // ------------------------------------------------------------
    logic [3:0] lost_q, retry_q;
    logic power_q, chan_wr;

    assign chan_wr = wr_byte && reg_addr_q == REG_RADIO_CHANNEL &&
                     byte_idx_q == 3'h0;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || chan_wr) begin
            lost_q <= COUNT_ZERO;
        end else if (packet_lost && lost_q != COUNT_MAX) begin
            lost_q <= lost_q + 4'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || new_packet_start) begin
            retry_q <= COUNT_ZERO;
        end else if (packet_retransmitted && retry_q != COUNT_MAX) begin
            retry_q <= retry_q + 4'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            power_q <= 1'b0;
        end else begin
            power_q <= power_detect_in;
        end
    end
    // the channel register lives elsewhere; it gets a write strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            radio_channel_write <= 1'b0;
        end else begin
            radio_channel_write <= chan_wr;
        end
    end

    // ------------------------------------------------------------
    // receive addresses
    // ------------------------------------------------------------
    logic [39:0] p0_q, p1_q;
    logic [7:0] p2_q, p3_q;
    logic addr_byte_ok, wr_p0, wr_p1;

    // low byte first; bytes past the set width are dropped
    assign addr_byte_ok = byte_idx_q < addr_bytes;
    assign wr_p0 = wr_byte && reg_addr_q == REG_PIPE0_RECEIVE_ADDRESS &&
                   addr_byte_ok;
    assign wr_p1 = wr_byte && reg_addr_q == REG_PIPE1_RECEIVE_ADDRESS &&
                   addr_byte_ok;
    genvar b;
    generate
        for (b = 0; b < 5; b++) begin : g_addr_byte
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    p0_q[8*b +: 8] <= PIPE0_RESET[8*b +: 8];
                    p1_q[8*b +: 8] <= PIPE1_RESET[8*b +: 8];
                end else begin
                    if (wr_p0 && byte_idx_q == 3'(b)) begin
                        p0_q[8*b +: 8] <= rx_byte;
                    end
                    if (wr_p1 && byte_idx_q == 3'(b)) begin
                        p1_q[8*b +: 8] <= rx_byte;
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            p2_q <= PIPE2_RESET;
            p3_q <= PIPE3_RESET;
        end else if (wr_byte && byte_idx_q == 3'h0) begin
            if (reg_addr_q == REG_PIPE2_ADDRESS_LOW_BYTE) begin
                p2_q <= rx_byte;
            end
            if (reg_addr_q == REG_PIPE3_ADDRESS_LOW_BYTE) begin
                p3_q <= rx_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] status_byte, read_byte;

    always_comb begin
        status_byte = BYTE_ZERO;
        status_byte[STAT_RX_BIT] = rx_flag_q;
        status_byte[STAT_TX_BIT] = tx_flag_q;
        status_byte[STAT_MAX_BIT] = max_flag_q;
        status_byte[STAT_PIPE_HI:STAT_PIPE_LO] = pipe_q;
        status_byte[STAT_FULL_BIT] = full_q;
    end
    always_comb begin
        read_byte = BYTE_ZERO;
        case (reg_addr_q)
            REG_RADIO_STATUS: if (byte_idx_q == 3'h0) read_byte = status_byte;
            REG_TRANSMIT_OBSERVE:
                if (byte_idx_q == 3'h0) read_byte = {lost_q, retry_q};
            REG_RECEIVED_POWER_DETECT:
                if (byte_idx_q == 3'h0) read_byte[POWER_BIT] = power_q;
            REG_PIPE0_RECEIVE_ADDRESS:
                if (byte_idx_q < BYTES_5) read_byte = p0_q[8*byte_idx_q +: 8];
            REG_PIPE1_RECEIVE_ADDRESS:
                if (byte_idx_q < BYTES_5) read_byte = p1_q[8*byte_idx_q +: 8];
            REG_PIPE2_ADDRESS_LOW_BYTE:
                if (byte_idx_q == 3'h0) read_byte = p2_q;
            REG_PIPE3_ADDRESS_LOW_BYTE:
                if (byte_idx_q == 3'h0) read_byte = p3_q;
            default: read_byte = BYTE_ZERO;
        endcase
    end
    // status goes out under the command byte, reads after it
    always_comb begin
        if (state_q == RSA_DATA && !is_write_q) begin
            tx_byte_d = read_byte;
        end else if (state_q == RSA_IDLE) begin
            tx_byte_d = status_byte;
        end else begin
            tx_byte_d = BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            spi_miso_oe_n <= 1'b1;
        end else begin
            spi_miso_oe_n <= csn_s;
        end
    end
    assign spi_miso = miso_bit;
    assign receive_ready_flag = rx_flag_q;
    assign transmit_done_flag = tx_flag_q;
    assign retry_limit_flag = max_flag_q;
    assign communication_blocked = max_flag_q;
    assign pipe0_receive_address = p0_q;
    assign pipe1_receive_address = p1_q;
    assign pipe2_receive_address = {p1_q[39:8], p2_q};
    assign pipe3_receive_address = {p1_q[39:8], p3_q};

endmodule
`default_nettype wire

/* File: rsa_spi_master.sv */
/* serial link master model for the radio register block.
   assumes a 50 MHz sys_clk and a mode 0 slave on miso. */
`timescale 1ns/1ns
`default_nettype none
module rsa_spi_master (
    input wire logic sys_clk,
    input wire logic miso,
    output logic sck,
    output logic csn_n,
    output logic mosi
);
    // ----------
    // frame engine
    // ----------
    initial begin
        sck = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b0;
    end
    // ten cycles a half bit: sck far below sys_clk/8
    task automatic half_bit();
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic frame(input logic [7:0] cmd, input int n,
        input logic [39:0] wd, output logic [7:0] st,
        output logic [39:0] rd);
        logic [47:0] tx, rx;
        rx = '0;
        tx = {wd, cmd};
        csn_n = 1'b0;
        half_bit();
        for (int b = 0; b <= n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                mosi = tx[8*b+i];
                half_bit();
                rx[8*b+i] = miso;
                sck = 1'b1;
                half_bit();
                sck = 1'b0;
            end
        end
        half_bit();
        csn_n = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
        half_bit();
        st = rx[7:0];
        rd = rx[47:8];
    endtask
endmodule
`default_nettype wire

/* File: rsa_radio_regs_properties.sv */
/* assertions on the radio register ports.
   assumes a bind into rsa_radio_regs with one clock. */
`timescale 1ns/1ns
`default_nettype none
module rsa_regs_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_csn_n,
    input wire logic spi_miso_oe_n,
    input wire logic payload_received,
    input wire logic packet_sent,
    input wire logic ack_received,
    input wire logic auto_ack_enable,
    input wire logic retry_limit_reached,
    input wire logic receive_ready_flag,
    input wire logic transmit_done_flag,
    input wire logic retry_limit_flag,
    input wire logic communication_blocked,
    input wire logic radio_channel_write,
    input wire logic [39:0] pipe1_receive_address,
    input wire logic [39:0] pipe2_receive_address,
    input wire logic [39:0] pipe3_receive_address
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_rx; payload_received |=> receive_ready_flag; endproperty
    a_rx: assert property (p_rx) else $error("rx not set");
    property p_rx_q;
        !payload_received && !receive_ready_flag |=> !receive_ready_flag;
    endproperty
    a_rx_q: assert property (p_rx_q) else $error("rx set");
    property p_tx; packet_sent && !auto_ack_enable |=> transmit_done_flag;
    endproperty
    a_tx: assert property (p_tx) else $error("tx not set");
    property p_ack; ack_received && auto_ack_enable |=> transmit_done_flag;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missed");
    property p_noack; packet_sent && auto_ack_enable && !ack_received &&
        !transmit_done_flag |=> !transmit_done_flag; endproperty
    a_noack: assert property (p_noack) else $error("no ack");
    property p_max; retry_limit_reached |=> retry_limit_flag; endproperty
    a_max: assert property (p_max) else $error("max not set");
    property p_blk; communication_blocked == retry_limit_flag; endproperty
    a_blk: assert property (p_blk) else $error("block");
    property p_up; pipe2_receive_address[39:8] == pipe1_receive_address[39:8]
        && pipe3_receive_address[39:8] == pipe1_receive_address[39:8];
    endproperty
    a_up: assert property (p_up) else $error("upper bytes");
    property p_oe; $fell(spi_csn_n) |-> ##[2:8] !spi_miso_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("oe late");
    c_blk: cover property (retry_limit_flag && communication_blocked);
    c_chan: cover property (radio_channel_write);
    c_ack: cover property ($rose(transmit_done_flag) && auto_ack_enable);
endmodule
bind rsa_radio_regs rsa_regs_chk u_chk (.*);
`default_nettype wire

/* File: test_radio_status_address_regs.sv */
/* bench for the radio status and address registers.
   assumes the link master model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module test_radio_status_address_regs;
    import rsa_pkg::*;
    // ----------
    // harness
    // ----------
    logic sys_clk = 1'b0, sys_rst = 1'b1, auto_ack = 1'b0, full = 1'b0;
    logic pwr = 1'b0;
    logic [2:0] head = 3'h7;
    logic [1:0] aw = 2'h3;
    logic [6:0] ev = 7'h00;
    logic [7:0] st;
    logic [39:0] rd, p0, p1, p2, p3;
    wire sck, csn_n, mosi, miso, oe_n, rf, tf, mf, blk;
    int failures = 0, n_tests = 0;
    always #10 sys_clk = ~sys_clk;
    rsa_spi_master u_master (.sys_clk, .miso, .sck, .csn_n, .mosi);
    rsa_radio_regs dut (.sys_clk, .sys_rst,
        .spi_sck(sck), .spi_csn_n(csn_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe_n(oe_n), .payload_received(ev[0]),
        .packet_sent(ev[1]), .retry_limit_reached(ev[2]),
        .ack_received(ev[3]), .packet_lost(ev[4]),
        .packet_retransmitted(ev[5]), .new_packet_start(ev[6]),
        .auto_ack_enable(auto_ack), .head_pipe_number(head),
        .transmit_fifo_full(full), .power_detect_in(pwr),
        .address_width_setting(aw), .receive_ready_flag(rf),
        .transmit_done_flag(tf), .retry_limit_flag(mf),
        .communication_blocked(blk), .radio_channel_write(),
        .pipe0_receive_address(p0), .pipe1_receive_address(p1),
        .pipe2_receive_address(p2), .pipe3_receive_address(p3));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic f(input logic [7:0] c, input int n, input logic [39:0] w);
        u_master.frame(c, n, w, st, rd);
    endtask
    task automatic pulse(input logic [6:0] m, input int n);
        repeat (n) begin
            @(negedge sys_clk) ev = m;
            @(negedge sys_clk) ev = 7'h00;
        end
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        check(oe_n, 1'b1);
        f(8'h08, 1, 0); check(st, 8'h0E); check(rd[7:0], 0);
        f(8'h09, 1, 0); check(rd[7:0], 0);
        f(8'h0A, 5, 0); check(rd, PIPE0_RESET);
        f(8'h0B, 5, 0); check(rd, PIPE1_RESET);
        f(8'h0C, 1, 0); check(rd[7:0], 8'hC3);
        f(8'h0D, 1, 0); check(rd[7:0], 8'hC4);
    endtask
    task automatic t_flags();
        pulse(7'h07, 1);
        check({rf, tf, mf, blk}, 4'hF);
        f(8'h27, 1, 40'h2F); f(8'h09, 1, 0); check(st, 8'h5E);
        auto_ack = 1'b1;
        pulse(7'h02, 1); check(tf, 1'b0);
        pulse(7'h08, 1); check(tf, 1'b1);
        f(8'h27, 1, 40'h70); f(8'h09, 1, 0); check(st, 8'h0E);
        check(blk, 1'b0);
    endtask
    task automatic t_fields();
        head = 3'h2; full = 1'b1; pwr = 1'b1;
        f(8'h09, 1, 0); check(st, 8'h05);
        check(rd[7:0], 8'h01);
        head = 3'h7; full = 1'b0; pwr = 1'b0;
    endtask
    task automatic t_count();
        // two losses past the cap
        pulse(7'h10, 17); pulse(7'h20, 3);
        f(8'h08, 1, 0); check(rd[7:0], 8'hF3);
        pulse(7'h60, 1); f(8'h08, 1, 0); check(rd[7:0], 8'hF0);
        f(8'h25, 1, 40'h10); f(8'h08, 1, 0); check(rd[7:0], 0);
    endtask
    task automatic t_addr();
        aw = 2'h1; f(8'h2B, 3, 40'hAABBCC);
        check(p1, 40'hC2C2AABBCC);
        check(p2, 40'hC2C2AABBC3);
        check(p3, 40'hC2C2AABBC4);
        aw = 2'h3; f(8'h2A, 5, 40'h0102030405);
        f(8'h0A, 5, 0); check(rd, 40'h0102030405);
        aw = 2'h2; f(8'h2A, 5, 40'hAAAAAAAAAA);
        check(p0, 40'h01AAAAAAAA);
    endtask
    task automatic print_verdict();
        if (failures == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        t_reset(); t_flags(); t_fields(); t_count(); t_addr();
        print_verdict();
    end
    // nineteen frames of at most 20 us
    initial begin
        #1000000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
